//--- design/irq_pri_ctrl.sv
// interrupt priority register, extended enable register and arbiter
`include "irq_pri_cfg.svh"

module irq_pri_ctrl (
  input  wire logic                      sys_clk,
  input  wire logic                      rst,
  input  wire logic [7:0]                sfr_addr,
  input  wire logic                      sfr_wr,
  input  wire logic                      sfr_rd,
  input  wire irq_pri_pkg::sfr_byte_type sfr_wdata,
  output irq_pri_pkg::sfr_byte_type      sfr_rdata_q,
  input  wire logic [5:0]                basic_req,
  input  wire logic [7:0]                ext_req,
  input  wire logic                      svc_take,
  input  wire logic                      svc_done,
  output logic                           irq_valid_q,
  output irq_pri_pkg::src_index_type     irq_index_q,
  output logic                           irq_high_q,
  output logic [1:0]                     svc_level_q
);
  import irq_pri_pkg::*;

  localparam int NSRC = `BASIC_SOURCES + `EXT_SOURCES;

  sfr_byte_type  basic_interrupt_priority;      // priority register
  sfr_byte_type  extended_interrupt_enable_one; // extended mask register
  svc_state_type svc_q;                         // service nesting state
  svc_state_type svc_d;                         // next nesting state
  logic [NSRC-1:0] all_req;                     // requests after masking
  logic [NSRC-1:0] high_sel;                    // sources at high level
  logic [NSRC-1:0] hi_req;                      // pending high requests
  logic [NSRC-1:0] lo_req;                      // pending low requests
  logic          hi_found;                      // any high pending
  logic          lo_found;                      // any low pending
  src_index_type hi_idx;                        // winning high source
  src_index_type lo_idx;                        // winning low source
  logic          irq_valid_d;                   // next presented flag
  src_index_type irq_index_d;                   // next presented source
  logic          irq_high_d;                    // next presented level
  sfr_byte_type  rdata_d;                       // next read data

  // lowest numbered pending source wins within one level
  function automatic logic pick_any(input logic [NSRC-1:0] vec);
    pick_any = |vec;
  endfunction

  function automatic src_index_type pick_first(
    input logic [NSRC-1:0] vec
  );
    pick_first = '0;
    for (int i = NSRC - 1; i >= 0; i--) begin
      if (vec[i]) begin
        pick_first = src_index_type'(i);
      end
    end
  endfunction

  // basic priority register, bits 7..6 read as ones
  sfr_byte_reg #(
    .ADDR  (`PRI_REG_ADDR),
    .RESET (`PRI_RESET),
    .WMASK (`PRI_WRITE_MASK),
    .ONES  (`PRI_READ_ONES)
  ) u_pri_reg (
    .sys_clk   (sys_clk),
    .rst       (rst),
    .sfr_addr  (sfr_addr),
    .sfr_wr    (sfr_wr),
    .sfr_wdata (sfr_wdata),
    .value_q   (basic_interrupt_priority)
  );

  // extended enable register, all bits writable, resets to zero
  sfr_byte_reg #(
    .ADDR  (`EXT_EN_REG_ADDR),
    .RESET (`EXT_EN_RESET),
    .WMASK (`EXT_EN_WRITE_MASK),
    .ONES  (`EXT_EN_READ_ONES)
  ) u_ext_en_reg (
    .sys_clk   (sys_clk),
    .rst       (rst),
    .sfr_addr  (sfr_addr),
    .sfr_wr    (sfr_wr),
    .sfr_wdata (sfr_wdata),
    .value_q   (extended_interrupt_enable_one)
  );

  // mask extended sources, basic ones are already enabled upstream
  always_comb begin
    all_req[`BASIC_SOURCES-1:0] = basic_req;
    // a cleared enable bit blocks its source, a set one passes it
    all_req[NSRC-1:`EXT_BASE_INDEX] =
      ext_req & extended_interrupt_enable_one;
  end

  // level of each source; extended sources always sit at low level
  always_comb begin
    high_sel = '0;
    // serial port 0 high when its bit is set, low when clear
    high_sel[`PRI_SER0_BIT] =
      basic_interrupt_priority[`PRI_SER0_BIT];
    high_sel[`PRI_TMR1_BIT] =
      basic_interrupt_priority[`PRI_TMR1_BIT];
    high_sel[`PRI_EXT1_BIT] =
      basic_interrupt_priority[`PRI_EXT1_BIT];
    high_sel[`PRI_TMR0_BIT] =
      basic_interrupt_priority[`PRI_TMR0_BIT];
    high_sel[`PRI_EXT0_BIT] =
      basic_interrupt_priority[`PRI_EXT0_BIT];
    high_sel[`PRI_TMR2_BIT] =
      basic_interrupt_priority[`PRI_TMR2_BIT];
  end

  // split pending requests by level and find a winner in each
  always_comb begin
    hi_req   = all_req & high_sel;
    lo_req   = all_req & ~high_sel;
    hi_found = pick_any(hi_req);
    lo_found = pick_any(lo_req);
    hi_idx   = pick_first(hi_req);
    lo_idx   = pick_first(lo_req);
  end

  // choose the request to present to the core
  always_comb begin
    irq_valid_d = 1'b0;
    irq_index_d = '0;
    irq_high_d  = 1'b0;
    case (svc_q)
      // idle: high wins over simultaneous low
      svc_none: begin
        if (hi_found) begin
          irq_valid_d = 1'b1;
          irq_index_d = hi_idx;
          irq_high_d  = 1'b1;
        end else if (lo_found) begin
          irq_valid_d = 1'b1;
          irq_index_d = lo_idx;
        end
      end
      // low routine running: only high may preempt
      svc_low: begin
        if (hi_found) begin
          irq_valid_d = 1'b1;
          irq_index_d = hi_idx;
          irq_high_d  = 1'b1;
        end
      end
      // high routine running: nothing preempts
      svc_high_alone,
      svc_high_over_low: begin
        irq_valid_d = 1'b0;
      end
      default: begin
        irq_valid_d = 1'b0;
      end
    endcase
    // withdraw while the core is taking the current one
    if (svc_take) begin
      irq_valid_d = 1'b0;
    end
  end

  // presented request, registered for the core
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      irq_valid_q <= 1'b0;
      irq_index_q <= '0;
      irq_high_q  <= 1'b0;
    end else begin
      irq_valid_q <= irq_valid_d;
      irq_index_q <= irq_index_d;
      irq_high_q  <= irq_high_d;
    end
  end

  // nesting of service routines: take enters, done returns one level
  always_comb begin
    svc_d = svc_q;
    case (svc_q)
      svc_none: begin
        if (svc_take && irq_valid_q) begin
          svc_d = irq_high_q ? svc_high_alone : svc_low;
        end
      end
      svc_low: begin
        if (svc_take && irq_valid_q && irq_high_q) begin
          svc_d = svc_high_over_low;
        end else if (svc_done) begin
          svc_d = svc_none;
        end
      end
      svc_high_alone: begin
        if (svc_done) begin
          svc_d = svc_none;
        end
      end
      svc_high_over_low: begin
        // back to the interrupted low routine
        if (svc_done) begin
          svc_d = svc_low;
        end
      end
      default: begin
        svc_d = svc_none;
      end
    endcase
  end

  // nesting state register
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      svc_q <= svc_none;
    end else begin
      svc_q <= svc_d;
    end
  end

  // service level shown to the core: 0 none, 1 low, 2 high
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      svc_level_q <= 2'h0;
    end else begin
      case (svc_d)
        svc_none:          svc_level_q <= 2'h0;
        svc_low:           svc_level_q <= 2'h1;
        svc_high_alone,
        svc_high_over_low: svc_level_q <= 2'h2;
        default:           svc_level_q <= 2'h0;
      endcase
    end
  end

  // read multiplexer, unmapped addresses read zero
  always_comb begin
    case (sfr_addr)
      `PRI_REG_ADDR:    rdata_d = basic_interrupt_priority;
      `EXT_EN_REG_ADDR: rdata_d = extended_interrupt_enable_one;
      default:          rdata_d = `RDATA_UNMAPPED;
    endcase
  end

  // read data, valid the cycle after a read strobe, else zero
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      sfr_rdata_q <= 8'h00;
    end else if (sfr_rd) begin
      sfr_rdata_q <= rdata_d;
    end else begin
      sfr_rdata_q <= 8'h00;
    end
  end
endmodule

//--- shared/irq_pri_cfg.svh
// constants for the priority and extended enable registers
`ifndef IRQ_PRI_CFG_SVH
`define IRQ_PRI_CFG_SVH

// special-function-register addresses
`define PRI_REG_ADDR       8'hB8
`define EXT_EN_REG_ADDR    8'hE6

// basic priority register layout
`define PRI_RESET          8'h00
`define PRI_WRITE_MASK     8'h3F
`define PRI_READ_ONES      8'hC0
`define PRI_EXT0_BIT       0
`define PRI_TMR0_BIT       1
`define PRI_EXT1_BIT       2
`define PRI_TMR1_BIT       3
`define PRI_SER0_BIT       4
`define PRI_TMR2_BIT       5

// extended enable register layout
`define EXT_EN_RESET       8'h00
`define EXT_EN_WRITE_MASK  8'hFF
`define EXT_EN_READ_ONES   8'h00
`define EXT_EN_SPI_BIT     0
`define EXT_EN_SMB_BIT     1
`define EXT_EN_WIN_BIT     2
`define EXT_EN_CNT_BIT     3
`define EXT_EN_CMP0F_BIT   4
`define EXT_EN_CMP0R_BIT   5
`define EXT_EN_CMP1F_BIT   6
`define EXT_EN_CMP1R_BIT   7

// source numbering: basic sources 0..5, extended sources 6..13
`define BASIC_SOURCES      6
`define EXT_SOURCES        8
`define EXT_BASE_INDEX     6
`define RDATA_UNMAPPED     8'h00

`endif

//--- shared/irq_pri_pkg.sv
// types shared by the priority and extended enable block
package irq_pri_pkg;
  // nesting level of the service routine currently running
  typedef enum logic [1:0] {
    svc_none,
    svc_low,
    svc_high_alone,
    svc_high_over_low
  } svc_state_type;

  typedef logic [7:0] sfr_byte_type;
  typedef logic [3:0] src_index_type;
endpackage

//--- design/sfr_byte_reg.sv
// one byte-wide special function register with write mask
module sfr_byte_reg #(
  parameter logic [7:0] ADDR  = 8'h00,
  parameter logic [7:0] RESET = 8'h00,
  parameter logic [7:0] WMASK = 8'hFF,
  parameter logic [7:0] ONES  = 8'h00
) (
  input  wire logic                  sys_clk,
  input  wire logic                  rst,
  input  wire logic [7:0]            sfr_addr,
  input  wire logic                  sfr_wr,
  input  wire irq_pri_pkg::sfr_byte_type sfr_wdata,
  output irq_pri_pkg::sfr_byte_type  value_q
);
  import irq_pri_pkg::*;

  sfr_byte_type store_q; // writable bits only

  // write only the masked bits, others stay at reset
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      store_q <= RESET & WMASK;
    end else if (sfr_wr && sfr_addr == ADDR) begin
      store_q <= sfr_wdata & WMASK;
    end
  end

  // unused bits read as their fixed level
  assign value_q = store_q | ONES;
endmodule

//--- sim/core_model.sv
// core model: vectors to a presented request after a set lag
module core_model (
  input  wire logic       sys_clk,
  input  wire logic       rst,
  input  wire logic       take_en,     // core accepts vectors
  input  wire logic [3:0] lag,         // cycles shown before vectoring
  input  wire logic       irq_valid_q,
  output logic            svc_take
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [3:0] wait_q;                  // cycles the request was shown

  // count while a request stands unanswered
  always_ff @(posedge sys_clk) begin
    if (rst || !irq_valid_q || svc_take) begin
      wait_q <= 4'h0;
    end else begin
      wait_q <= wait_q + 4'h1;
    end
  end

  // one pulse per presented request once the lag has run
  always_ff @(posedge sys_clk) begin
    svc_take <= !rst && take_en && irq_valid_q && !svc_take
                && wait_q >= lag;
  end
endmodule

//--- sim/irq_pri_ctrl_asserts.sv
// port checker for the priority and extended enable block
`include "irq_pri_cfg.svh"

module irq_pri_ctrl_asserts (
  input wire logic                      sys_clk,
  input wire logic                      rst,
  input wire logic [7:0]                sfr_addr,
  input wire logic                      sfr_rd,
  input wire irq_pri_pkg::sfr_byte_type sfr_rdata_q,
  input wire logic                      svc_take,
  input wire logic                      svc_done,
  input wire logic                      irq_valid_q,
  input wire irq_pri_pkg::src_index_type irq_index_q,
  input wire logic                      irq_high_q,
  input wire logic [1:0]                svc_level_q
);
  timeunit 1ns;
  timeprecision 1ns;
  import irq_pri_pkg::*;
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (rst);
  // accepted vector from idle at low or high level, and over a low routine
  sequence s_take_idle;
    svc_level_q == 2'h0 && irq_valid_q && svc_take && !irq_high_q;
  endsequence
  sequence s_take_high;
    svc_level_q == 2'h0 && irq_valid_q && svc_take && irq_high_q;
  endsequence
  sequence s_take_over;
    svc_level_q == 2'h1 && irq_valid_q && svc_take;
  endsequence

  a_rdata_idle: assert property (!sfr_rd |=> sfr_rdata_q == 8'h00)
    else $error("read data not zero without read");
  a_pri_ones: assert property (
    sfr_rd && sfr_addr == `PRI_REG_ADDR
    |=> (sfr_rdata_q & `PRI_READ_ONES) == `PRI_READ_ONES)
    else $error("priority upper bits not read as ones");
  a_high_blocks: assert property (
    svc_level_q == 2'h2 |-> !irq_valid_q)
    else $error("request shown during high routine");
  a_low_only_high: assert property (
    svc_level_q == 2'h1 && irq_valid_q |-> irq_high_q)
    else $error("low request shown during low routine");
  a_ext_low: assert property (
    irq_valid_q && irq_index_q >= 4'h6 |-> !irq_high_q)
    else $error("extended source shown as high");
  a_take_drops: assert property (
    irq_valid_q && svc_take |=> !irq_valid_q)
    else $error("request stayed after vector");
  a_take_low_lvl: assert property (
    s_take_idle |=> svc_level_q == 2'h1)
    else $error("low vector did not start low routine");
  a_take_high_lvl: assert property (
    s_take_high |=> svc_level_q == 2'h2)
    else $error("high vector did not start high routine");
  a_take_over_lvl: assert property (
    s_take_over |=> svc_level_q == 2'h2)
    else $error("high vector did not preempt");
  a_done_return: assert property (
    svc_level_q == 2'h1 && svc_done && !svc_take |=> svc_level_q == 2'h0)
    else $error("return from low routine failed");
endmodule

bind irq_pri_ctrl irq_pri_ctrl_asserts u_irq_pri_ctrl_asserts (
  .sys_clk(sys_clk), .rst(rst), .sfr_addr(sfr_addr), .sfr_rd(sfr_rd),
  .sfr_rdata_q(sfr_rdata_q), .svc_take(svc_take), .svc_done(svc_done),
  .irq_valid_q(irq_valid_q), .irq_index_q(irq_index_q),
  .irq_high_q(irq_high_q), .svc_level_q(svc_level_q));

//--- sim/irq_pri_ctrl_test.sv
// self-checking bench for the priority and extended enable block
module irq_pri_ctrl_test;
  timeunit 1ns;
  timeprecision 1ns;
  import irq_pri_pkg::*;
  logic          sys_clk = 0, rst = 1, sfr_wr = 0, sfr_rd = 0;
  logic          svc_done = 0, take_en = 0, svc_take;
  logic [7:0]    sfr_addr = 8'h00, sfr_wdata = 8'h00, ext_req = 8'h00;
  logic [5:0]    basic_req = 6'h00;       // basic request levels
  logic [3:0]    lag = 4'h0;              // core answer delay
  sfr_byte_type  sfr_rdata_q;
  src_index_type irq_index_q;
  logic          irq_valid_q, irq_high_q;
  logic [1:0]    svc_level_q;
  int            miscompares = 0, checks = 0;

  // 50 ns clock
  always #25 sys_clk = ~sys_clk;

  irq_pri_ctrl u_irq_pri_ctrl (.sys_clk(sys_clk), .rst(rst),
    .sfr_addr(sfr_addr), .sfr_wr(sfr_wr), .sfr_rd(sfr_rd),
    .sfr_wdata(sfr_wdata), .sfr_rdata_q(sfr_rdata_q),
    .basic_req(basic_req), .ext_req(ext_req), .svc_take(svc_take),
    .svc_done(svc_done), .irq_valid_q(irq_valid_q),
    .irq_index_q(irq_index_q), .irq_high_q(irq_high_q),
    .svc_level_q(svc_level_q));
  core_model u_core_model (.sys_clk(sys_clk), .rst(rst),
    .take_en(take_en), .lag(lag), .irq_valid_q(irq_valid_q),
    .svc_take(svc_take));

  // compare and count
  task automatic chk(string name, logic [7:0] seen, logic [7:0] exp);
    checks++;
    if (seen !== exp) begin
      miscompares++;
      $display("mismatch %s expected %h seen %h", name, exp, seen);
    end
  endtask
  // one register write
  task automatic wr(logic [7:0] a, logic [7:0] d);
    @(posedge sys_clk);
    sfr_addr <= a;
    sfr_wdata <= d;
    sfr_wr <= 1'b1;
    @(posedge sys_clk);
    sfr_wr <= 1'b0;
  endtask
  // one register read, data checked the cycle after
  task automatic rd(logic [7:0] a, logic [7:0] exp);
    @(posedge sys_clk);
    sfr_addr <= a;
    sfr_rd <= 1'b1;
    @(posedge sys_clk);
    sfr_rd <= 1'b0;
    @(negedge sys_clk);
    chk("read data", sfr_rdata_q, exp);
  endtask
  // bounded wait for a service level
  task automatic wait_lvl(logic [1:0] exp);
    int n;
    n = 0;
    do begin
      @(negedge sys_clk);
      n++;
    end while (svc_level_q !== exp && n < 30);
    chk("service level", {6'h00, svc_level_q}, {6'h00, exp});
  endtask
  // settle two cycles then check the presented request
  task automatic shown(logic [7:0] idx, logic hi);
    repeat (2) @(posedge sys_clk);
    @(negedge sys_clk);
    chk("valid", {7'h00, irq_valid_q}, 8'h01);
    chk("source", {4'h0, irq_index_q}, idx);
    chk("high", {7'h00, irq_high_q}, {7'h00, hi});
  endtask

  // reset values, masks, unmapped place
  task automatic reg_access;
    rd(8'hB8, 8'hC0);
    rd(8'hE6, 8'h00);
    rd(8'h5A, 8'h00);
    wr(8'hB8, 8'h21);
    rd(8'hB8, 8'hE1);
    wr(8'hE6, 8'hA5);
    wr(8'h5A, 8'hFF);
    rd(8'hE6, 8'hA5);
  endtask
  // each priority bit alone raises its source over the rest
  task automatic priority_bits;
    wr(8'hE6, 8'h00);
    basic_req <= 6'h3F;
    for (int i = 0; i < 6; i++) begin
      wr(8'hB8, 8'h01 << i);
      shown(8'(i), 1'b1);
    end
    wr(8'hB8, 8'h00);
    shown(8'h00, 1'b0);
    @(posedge sys_clk);
    basic_req <= 6'h00;
  endtask
  // every enable bit passes only its own source
  task automatic ext_masks;
    @(posedge sys_clk);
    ext_req <= 8'hFF;
    repeat (3) @(posedge sys_clk);
    @(negedge sys_clk);
    chk("masked", {7'h00, irq_valid_q}, 8'h00);
    for (int j = 0; j < 8; j++) begin
      wr(8'hE6, 8'h01 << j);
      shown(8'(6 + j), 1'b0);
    end
    @(posedge sys_clk);
    ext_req <= 8'h00;
  endtask
  // low routine, ignored low, high preemption, returns
  task automatic preemption;
    wr(8'hB8, 8'h08);
    lag <= 4'h2;
    take_en <= 1'b1;
    basic_req <= 6'h02;
    wait_lvl(2'd1);
    repeat (3) @(posedge sys_clk);
    @(negedge sys_clk);
    chk("low held", {7'h00, irq_valid_q}, 8'h00);
    @(posedge sys_clk);
    basic_req <= 6'h0A;
    wait_lvl(2'd2);
    chk("high held", {7'h00, irq_valid_q}, 8'h00);
    @(posedge sys_clk);
    basic_req <= 6'h00;
    svc_done <= 1'b1;
    @(posedge sys_clk);
    svc_done <= 1'b0;
    wait_lvl(2'd1);
    @(posedge sys_clk);
    svc_done <= 1'b1;
    @(posedge sys_clk);
    svc_done <= 1'b0;
    wait_lvl(2'd0);
    // high request from idle runs alone and shuts out the low one
    @(posedge sys_clk);
    basic_req <= 6'h0A;
    shown(8'h03, 1'b1);
    wait_lvl(2'h2);
    chk("alone held", {7'h00, irq_valid_q}, 8'h00);
    @(posedge sys_clk);
    basic_req <= 6'h00;
    svc_done <= 1'b1;
    @(posedge sys_clk);
    svc_done <= 1'b0;
    wait_lvl(2'h0);
  endtask

  // verdict and end of run
  task automatic complete_run;
    $display("checks %0d miscompares %0d", checks, miscompares);
    if (miscompares == 0 && checks > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask

  // main sequence
  initial begin
    repeat (4) @(posedge sys_clk);
    rst <= 1'b0;
    reg_access;
    priority_bits;
    ext_masks;
    preemption;
    complete_run;
  end
  // watchdog well past the expected run
  initial begin
    repeat (3000) @(posedge sys_clk);
    miscompares++;
    complete_run;
  end
endmodule
